// *** dv/spi_master_model.sv ***
// Serial bus master model, mode 0, for the memory front end
`timescale 1ns/10ps
module spi_master_model
(
  input  wire clk_sys,
  input  wire so_o,
  input  wire so_oe,
  output reg  cs_n,
  output reg  sck,
  output reg  si,
  output reg  wp_n,
  output reg  hold_n
);
  reg [7:0] rx_byte;
  reg       oe_seen;
  reg       so_float;
  wire      so_line;
  event     got;
  // Released line toggles so a stale bit never reads as valid
  assign so_line = so_oe ? so_o : so_float;
  initial
  begin
    cs_n     = 1'b1;
    sck      = 1'b0;
    si       = 1'b0;
    wp_n     = 1'b1;
    hold_n   = 1'b1;
    so_float = 1'b0;
    oe_seen  = 1'b0;
  end
  always @(posedge clk_sys)
  begin
    so_float <= ~so_float;
    if (so_oe)
      oe_seen <= 1'b1;
  end
  task wait_clk(input integer n);
    repeat (n) @(negedge clk_sys);
  endtask
  task begin_frame;
  begin
    oe_seen = 1'b0;
    cs_n    = 1'b0;
    wait_clk(4);
  end
  endtask
  task end_frame;
  begin
    wait_clk(4);
    cs_n = 1'b1;
    wait_clk(12);
  end
  endtask
  // Bit taken at end of high phase, well after the output update
  task xfer(input [7:0] tx, input pz, input chk);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
      begin
        si = tx[i];
        wait_clk(4);
        sck = 1'b1;
        wait_clk(4);
        rx_byte[i] = so_line;
        sck = 1'b0;
        if (pz && i == 4)
        begin
          wait_clk(2);
          hold_n = 1'b0;
          repeat (4)
          begin
            wait_clk(4);
            sck = ~sck;
          end
          wait_clk(4);
          hold_n = 1'b1;
        end
      end
      if (chk)
        -> got;
    end
  endtask
endmodule

// *** dv/spi_nv_memory_protect_props.sv ***
// Port-level assertions for the protected serial memory front end
`timescale 1ns/10ps
module spi_nv_memory_protect_props
(
  input wire       clk_sys,
  input wire       rst_n,
  input wire       cs_n,
  input wire       sck,
  input wire       si,
  input wire       wp_n,
  input wire       hold_n,
  input wire       so_o,
  input wire       so_oe,
  input wire [7:0] protection_status
);
  reg [2:0] wp_low_q;
  reg [2:0] hold_low_q;
  // ------
  // Pin run lengths
  // ------
  // Saturating, so long holds cost no wide counter
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wp_low_q   <= 3'h0;
      hold_low_q <= 3'h0;
    end
    else
    begin
      wp_low_q   <= wp_n ? 3'h0 : wp_low_q + {2'h0, wp_low_q != 3'h7};
      hold_low_q <= hold_n ? 3'h0 : hold_low_q + {2'h0, hold_low_q != 3'h7};
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_fixed_bits_zero: assert property (
    {protection_status[6:4], protection_status[0]} == 4'h0) else $error("fixed bits set");
  a_idle_out_off: assert property (cs_n [*6] |-> !so_oe) else $error("out on idle");
  a_oe_needs_sel: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("out on unselected");
  a_guard_needs_latch: assert property (
    ($changed(protection_status[7]) || $changed(protection_status[3:2]))
    |-> $past(protection_status[1])) else $error("status changed, latch clear");
  a_latch_drop_end: assert property ($fell(protection_status[1]) |-> cs_n)
    else $error("latch cleared mid frame");
  a_pin_locks_status: assert property (
    wp_low_q == 3'h7 && protection_status[7]
    |=> $stable({protection_status[7], protection_status[3:2]})) else $error("pin lock broken");
  a_pause_out_off: assert property (hold_low_q == 3'h7 |-> !so_oe)
    else $error("out during pause");
  a_out_after_fall: assert property (
    so_oe && $past(so_oe) && $changed(so_o) |-> !$past(sck, 2)) else $error("out moved early");
  c_read_out: cover property ($rose(so_oe));
  c_guard_set: cover property ($changed(protection_status[3:2]));
  c_pause: cover property (hold_low_q == 3'h7 && !cs_n);
endmodule

// *** dv/test_spi_nv_memory_protect.sv ***
// Self-checking bench for the protected serial memory front end
`timescale 1ns/10ps
module test_spi_nv_memory_protect;
  reg        clk_sys;
  reg        rst_n;
  wire       cs_n;
  wire       sck;
  wire       si;
  wire       wp_n;
  wire       hold_n;
  wire       so_o;
  wire       so_oe;
  wire [7:0] protection_status;
  reg  [7:0] shadow [0:2047];
  reg  [7:0] exp_q [$];
  reg  [1:0] guard;
  integer    n_mismatch;
  integer    checks_done;
  integer    seed;
  integer    g;
  spi_nv_memory_protect dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
    .si(si), .wp_n(wp_n), .hold_n(hold_n), .so_o(so_o), .so_oe(so_oe),
    .protection_status(protection_status));
  spi_master_model m_u (.clk_sys(clk_sys), .so_o(so_o), .so_oe(so_oe), .cs_n(cs_n),
    .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task check(input string what, input [7:0] seen, input [7:0] expv);
  begin
    checks_done = checks_done + 1;
    if (seen !== expv)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s exp %h seen %h", what, expv, seen);
    end
  end
  endtask
  task final_report;
  begin
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  function open(input [10:0] a);
    open = guard == 2'h0 || (guard == 2'h1 && a < 11'h600) || (guard == 2'h2 && a < 11'h400);
  endfunction
  task cmd(input [7:0] op);
  begin
    m_u.begin_frame;
    m_u.xfer(op, 1'b0, 1'b0);
    m_u.end_frame;
  end
  endtask
  task status_is(input [7:0] v);
  begin
    exp_q.push_back(v);
    m_u.begin_frame;
    m_u.xfer(8'h05, 1'b0, 1'b0);
    m_u.xfer(8'h00, 1'b0, 1'b1);
    m_u.end_frame;
    check("status port", protection_status, v);
  end
  endtask
  task status_store(input [7:0] v, input latch);
  begin
    if (latch)
      cmd(8'h06);
    m_u.begin_frame;
    m_u.xfer(8'h01, 1'b0, 1'b0);
    m_u.xfer(v, 1'b0, 1'b0);
    m_u.end_frame;
  end
  endtask
  task mem(input [7:0] op, input [15:0] a, input integer n, input en, input pz);
    integer    i;
    reg [10:0] ai;
    reg [31:0] r;
    begin
      m_u.begin_frame;
      m_u.xfer(op, 1'b0, 1'b0);
      m_u.xfer(a[15:8], 1'b0, 1'b0);
      m_u.xfer(a[7:0], 1'b0, 1'b0);
      for (i = 0; i < n; i = i + 1)
      begin
        ai = a[10:0] + i[10:0];
        r = $random(seed);
        en = en && open(ai);
        if (op == 8'h03)
          exp_q.push_back(shadow[ai]);
        else if (en)
          shadow[ai] = r[7:0];
        m_u.xfer(r[7:0], pz && i == 0, op == 8'h03);
      end
      m_u.end_frame;
    end
  endtask
  initial
  begin
    forever
    begin
      @(m_u.got);
      check("shifted byte", m_u.rx_byte, exp_q.pop_front());
    end
  end
  initial
  begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
  initial
  begin
    n_mismatch  = 0;
    checks_done = 0;
    seed        = 35;
    guard       = 2'h0;
    rst_n       = 1'b0;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    status_is(8'h00);
    cmd(8'h06);
    status_is(8'h02);
    cmd(8'h04);
    status_is(8'h00);
    cmd(8'h06);
    mem(8'h02, 16'hf7fe, 3, 1'b1, 1'b0);
    status_is(8'h00);
    mem(8'h03, 16'h07fe, 3, 1'b0, 1'b1);
    mem(8'h02, 16'h07fe, 1, 1'b0, 1'b0);
    mem(8'h03, 16'h07fe, 1, 1'b0, 1'b0);
    for (g = 0; g < 4; g = g + 1)
    begin
      guard = g[1:0];
      status_store({4'h7, guard, 2'h3}, 1'b1);
      status_is({4'h0, guard, 2'h0});
      cmd(8'h06);
      mem(8'h02, 16'h03ff, 2, 1'b1, 1'b0);
      cmd(8'h06);
      mem(8'h02, 16'h05ff, 2, 1'b1, 1'b0);
      mem(8'h03, 16'h03ff, 2, 1'b0, 1'b0);
      mem(8'h03, 16'h05ff, 2, 1'b0, 1'b0);
    end
    status_store(8'h8c, 1'b1);
    m_u.wp_n = 1'b0;
    status_store(8'h00, 1'b1);
    status_is(8'h8c);
    m_u.wp_n = 1'b1;
    status_store(8'h00, 1'b0);
    status_is(8'h8c);
    status_store(8'h00, 1'b1);
    status_is(8'h00);
    m_u.begin_frame;
    m_u.xfer(8'hff, 1'b0, 1'b0);
    m_u.xfer(8'h05, 1'b0, 1'b0);
    m_u.xfer(8'h00, 1'b0, 1'b0);
    m_u.end_frame;
    check("oe on bad op", {7'h0, m_u.oe_seen}, 8'h00);
    final_report;
  end
endmodule
bind spi_nv_memory_protect spi_nv_memory_protect_props props_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n),
  .so_o(so_o), .so_oe(so_oe), .protection_status(protection_status));

// *** hw/nv_array.v ***
// Byte-wide memory array held in flip-flops, one write port, one read port
`timescale 1ns/10ps
module nv_array
#(
  parameter AW = 11,
  parameter DEPTH = 2048
)
(
  input  wire          clk_sys,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [7:0]    wdata,
  input  wire [AW-1:0] raddr,
  output wire [7:0]    rdata
);
  // No reset: contents stand for nonvolatile storage
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge clk_sys)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  assign rdata = mem[raddr];
endmodule

// *** hw/pin_sync.v ***
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync
#(
  parameter W    = 4,
  parameter INIT = 4'h0
)
(
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] meta_q;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= INIT;
      dout   <= INIT;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// *** hw/spi_nv_memory_protect.v ***
// Serial slave front end with status register and write protection
`timescale 1ns/10ps
`include "nv_protect_map.vh"
module spi_nv_memory_protect
#(
  parameter AW    = `ADDR_W,
  parameter DEPTH = 2048
)
(
  input  wire clk_sys,
  input  wire rst_n,
  input  wire cs_n,
  input  wire sck,
  input  wire si,
  input  wire wp_n,
  input  wire hold_n,
  output reg  so_o,
  output reg  so_oe,
  output reg  [7:0] protection_status
);
  // ----------------------------------------------------------------
  // Phases and pin sampling
  // ----------------------------------------------------------------
  localparam [2:0] PH_OPCODE = 3'd0;
  localparam [2:0] PH_ADDR_HI = 3'd1;
  localparam [2:0] PH_ADDR_LO = 3'd2;
  localparam [2:0] PH_DATA_IN = 3'd3;
  localparam [2:0] PH_DATA_OUT = 3'd4;
  localparam [2:0] PH_STATUS_IN = 3'd5;
  localparam [2:0] PH_IGNORE = 3'd6;

  wire [4:0] pins_s;

  pin_sync #(.W(5), .INIT(5'h1f)) u_sync
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({cs_n, sck, si, wp_n, hold_n}),
    .dout    (pins_s)
  );

  wire cs_s   = pins_s[4];
  wire sck_s  = pins_s[3];
  wire si_s   = pins_s[2];
  wire wp_s   = pins_s[1];
  wire hold_s = pins_s[0];

  reg        cs_q;
  reg        sck_q;
  reg        paused_q;
  reg        sck_armed_q;
  reg [2:0]  phase_q;
  reg [2:0]  bit_q;
  reg [7:0]  shift_q;
  reg [7:0]  opcode_q;
  reg [AW-1:0] addr_q;
  reg [7:0]  out_q;
  reg        latch_q;
  reg        pin_guard_q;
  reg [1:0]  guard_q;
  reg        burst_stop_q;
  reg        wr_q;
  reg        clr_pend_q;
  reg        out_live_q;

  wire cs_fall = cs_q & ~cs_s;
  wire cs_rise = ~cs_q & cs_s;
  wire active  = ~cs_s & ~paused_q;
  wire sck_rise = active & sck_armed_q & ~sck_q & sck_s;
  wire sck_fall = active & sck_q & ~sck_s;
  wire [7:0] byte_in = {shift_q[6:0], si_s};
  wire last_bit = (bit_q == 3'd7);

  // ----------------------------------------------------------------
  // Protection decode
  // ----------------------------------------------------------------
  reg guarded;
  always @*
  begin
    case (guard_q)
      2'b00:   guarded = 1'b0;
      2'b01:   guarded = (addr_q >= `GUARD_QUARTER);
      2'b10:   guarded = (addr_q >= `GUARD_HALF);
      2'b11:   guarded = 1'b1;
      default: guarded = 1'b1;
    endcase
  end

  // Pin never blocks the array
  wire array_ok = latch_q & ~guarded & ~burst_stop_q;
  wire status_ok = latch_q & ~(pin_guard_q & ~wp_s);

  wire [7:0] status_word;
  assign status_word = {pin_guard_q, 3'b000, guard_q, latch_q, 1'b0};

  wire [7:0] rd_byte;
  wire [AW-1:0] addr_next = addr_q + {{(AW-1){1'b0}}, 1'b1};

  nv_array #(.AW(AW), .DEPTH(DEPTH)) u_array
  (
    .clk_sys (clk_sys),
    .we      (wr_q),
    .waddr   (addr_q),
    .wdata   (shift_q),
    .raddr   (addr_q),
    .rdata   (rd_byte)
  );

  // ----------------------------------------------------------------
  // Pause tracking
  // ----------------------------------------------------------------
  // Pause level only acts while the serial clock is low
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      paused_q <= 1'b0;
    else if (cs_s)
      paused_q <= 1'b0;
    else if (!sck_s)
      paused_q <= ~hold_s;
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_q         <= 1'b1;
      sck_q        <= 1'b0;
      sck_armed_q  <= 1'b0;
      phase_q      <= PH_OPCODE;
      bit_q        <= 3'd0;
      shift_q      <= 8'h00;
      opcode_q     <= 8'h00;
      addr_q       <= {AW{1'b0}};
      out_q        <= 8'h00;
      latch_q      <= 1'b0;
      pin_guard_q  <= 1'b0;
      guard_q      <= 2'b00;
      burst_stop_q <= 1'b0;
      wr_q         <= 1'b0;
      clr_pend_q   <= 1'b0;
      out_live_q   <= 1'b0;
      so_o         <= 1'b0;
      so_oe        <= 1'b0;
      protection_status <= `SR_RESET;
    end
    else
    begin
      cs_q  <= cs_s;
      sck_q <= sck_s;
      wr_q  <= 1'b0;
      protection_status <= status_word;
      // Byte commit happens the cycle after its last bit
      if (wr_q && !burst_stop_q)
        addr_q <= addr_next;
      if (cs_fall)
      begin
        // Mode 3 idles high: first rising edge only after a low is seen
        sck_armed_q  <= ~sck_s;
        phase_q      <= PH_OPCODE;
        bit_q        <= 3'd0;
        burst_stop_q <= 1'b0;
        out_live_q   <= 1'b0;
      end
      else if (!cs_s && !sck_s)
        sck_armed_q <= 1'b1;
      if (cs_rise)
      begin
        so_oe <= 1'b0;
        out_live_q <= 1'b0;
        phase_q <= PH_OPCODE;
        if (clr_pend_q)
          latch_q <= 1'b0;
        clr_pend_q <= 1'b0;
      end
      else if (cs_s || paused_q)
        so_oe <= 1'b0;
      else
        // Resume drives the held bit again, otherwise the master reads a floating line
        so_oe <= out_live_q;
      if (sck_fall && phase_q == PH_DATA_OUT)
      begin
        out_live_q <= 1'b1;
        so_oe <= 1'b1;
        so_o  <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
      if (sck_rise && phase_q != PH_IGNORE)
      begin
        bit_q   <= bit_q + 3'd1;
        shift_q <= byte_in;
        if (last_bit)
        begin
          case (phase_q)
            PH_OPCODE:
            begin
              opcode_q <= byte_in;
              case (byte_in)
                `OP_SET_LATCH:
                begin
                  latch_q <= 1'b1;
                  phase_q <= PH_IGNORE;
                end
                `OP_CLEAR_LATCH:
                begin
                  clr_pend_q <= 1'b1;
                  phase_q    <= PH_IGNORE;
                end
                `OP_STATUS_FETCH:
                begin
                  out_q   <= status_word;
                  phase_q <= PH_DATA_OUT;
                end
                `OP_STATUS_STORE:
                begin
                  if (latch_q)
                    clr_pend_q <= 1'b1;
                  phase_q <= PH_STATUS_IN;
                end
                `OP_READ_MEM, `OP_WRITE_MEM:
                begin
                  if (byte_in == `OP_WRITE_MEM && latch_q)
                    clr_pend_q <= 1'b1;
                  phase_q <= PH_ADDR_HI;
                end
                default: phase_q <= PH_IGNORE;
              endcase
            end
            PH_ADDR_HI:
            begin
              addr_q[AW-1:8] <= byte_in[AW-9:0];
              phase_q <= PH_ADDR_LO;
            end
            PH_ADDR_LO:
            begin
              addr_q[7:0] <= byte_in;
              if (opcode_q == `OP_READ_MEM)
              begin
                out_q   <= rd_byte;
                phase_q <= PH_DATA_OUT;
              end
              else
                phase_q <= PH_DATA_IN;
            end
            PH_DATA_IN:
            begin
              if (array_ok)
                wr_q <= 1'b1;
              else
                burst_stop_q <= 1'b1;
            end
            PH_STATUS_IN:
            begin
              if (status_ok)
              begin
                pin_guard_q <= byte_in[`SR_PIN_GUARD_BIT];
                guard_q <= {byte_in[`SR_GUARD_HI_BIT], byte_in[`SR_GUARD_LO_BIT]};
              end
              phase_q <= PH_IGNORE;
            end
            PH_DATA_OUT:
            begin
              // Input ignored while shifting out
              if (opcode_q == `OP_READ_MEM)
              begin
                addr_q <= addr_next;
                out_q  <= rd_byte;
              end
              else
                phase_q <= PH_IGNORE;
            end
            default: phase_q <= PH_IGNORE;
          endcase
        end
      end
      // Read prefetch: load next byte after the address step
      if (phase_q == PH_DATA_OUT && opcode_q == `OP_READ_MEM && bit_q == 3'd0
          && !sck_fall && sck_q && sck_s)
        out_q <= rd_byte;
    end
  end
endmodule

// *** inc/nv_protect_map.vh ***
// Constants for the serial nonvolatile memory front end
//
// What this block does
// - Status bits 0 and 4..6 ignore writes and always read zero.
// - Status bit 1 mirrors write latch, zero after reset, not directly writable.
// - Write latch set only by set command, cleared by clear command or auto-clear.
// - Block guard bits 2 and 3 clear to 00 on reset and are not retained.
// - Guard 00 none, 01 600h-7FFh, 10 400h-7FFh, 11 whole array.
// - Array write refused only if latch clear or address guarded; pin never blocks.
// - Bit 7 set and protect pin low blocks status writes; else pin ignored.
// - Master sets latch before status write; status write ignored with latch clear.
// - Accepted status write loads bits 7, 3, 2 from data byte; is a write.
// - Status fetch shifts out one status byte, MSB first.
// - Write takes two address bytes; low 11 bits used, upper five ignored.
// - Write burst stores bytes at incrementing addresses, wrapping 7FFh to 000h.
// - Each byte commits at its eighth bit, no page buffer, no busy.
// - Burst reaching guarded address stops incrementing and drops further bytes.
// - Chip select rising ends a memory write.
// - Read outputs data on next eight clocks MSB first, input ignored.
// - Read burst outputs incrementing addresses, wrapping 7FFh to zero.
// - Chip select rising ends read and tristates output.
// - Pause low while clock low freezes; high while clock low resumes.
// - While paused, clock toggles do not advance the operation; select rising still ends it.
// - Opcodes: set latch 06h, clear latch 04h, status fetch 05h, first byte.
// - Opcodes: status store 01h, read memory 03h, write memory 02h.
// - Latch auto-clears on select rising after clear, status store or write.
// - Unknown opcode: ignore input until next select fall, output tristated.
`ifndef NV_PROTECT_MAP_VH
`define NV_PROTECT_MAP_VH

`define OP_SET_LATCH     8'h06
`define OP_CLEAR_LATCH   8'h04
`define OP_STATUS_FETCH  8'h05
`define OP_STATUS_STORE  8'h01
`define OP_READ_MEM      8'h03
`define OP_WRITE_MEM     8'h02

`define SR_PIN_GUARD_BIT 7
`define SR_GUARD_HI_BIT  3
`define SR_GUARD_LO_BIT  2
`define SR_LATCH_BIT     1
`define SR_RESET         8'h00

`define ADDR_W           11
`define ADDR_TOP         11'h7ff
`define GUARD_QUARTER    11'h600
`define GUARD_HALF       11'h400
`define GUARD_ALL        11'h000

`endif
